/* src/monitor_channel.sv */
`timescale 1ns/100ps
module monitor_channel #(
	parameter int NUM_AXES = 2,
	parameter int NUM_INST = 4,
	parameter int NUM_BRAKES = 2,
	parameter int VW = 32
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic src_wr, // source selector write
	input wire logic axis_wr, // axis selector write
	input wire logic inst_wr, // instance selector write
	input wire logic [7:0] wr_data, // selector write value
	input wire logic [7:0] fn_state [NUM_AXES][NUM_INST][safety_monitor_pkg::NUM_FN], // fn states
	input wire logic [7:0] brake_state [NUM_BRAKES], // brake machine states
	input wire logic [VW-1:0] position [NUM_AXES], // safe position
	input wire logic [VW-1:0] abs_position [NUM_AXES], // safe absolute position
	input wire logic [VW-1:0] accel [NUM_AXES], // acceleration
	input wire logic [VW-1:0] speed [NUM_AXES], // speed
	output logic [7:0] source_q, // held source code
	output logic [7:0] axis_q, // held axis
	output logic [7:0] inst_q, // held instance
	output logic [VW-1:0] value_q, // monitored value
	output logic reject_q // pulse: write out of range
);
	localparam logic [7:0] AXIS_MAX = 8'(NUM_AXES);

	logic [VW-1:0] value_d;
	logic src_ok, axis_ok, inst_ok;

	assign src_ok = wr_data <= safety_monitor_pkg::SRC_MAX;
	assign axis_ok = wr_data >= safety_monitor_pkg::AXIS_MIN && wr_data <= AXIS_MAX;
	assign inst_ok = wr_data >= safety_monitor_pkg::INST_MIN
		&& wr_data <= safety_monitor_pkg::INST_MAX;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			source_q <= safety_monitor_pkg::SRC_RESET;
		end else if (src_wr && src_ok) begin
			source_q <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			axis_q <= safety_monitor_pkg::AXIS_RESET;
		end else if (axis_wr && axis_ok) begin
			axis_q <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inst_q <= safety_monitor_pkg::INST_RESET;
		end else if (inst_wr && inst_ok) begin
			inst_q <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reject_q <= 1'b0;
		end else begin
			reject_q <= (src_wr && !src_ok) || (axis_wr && !axis_ok) || (inst_wr && !inst_ok);
		end
	end

	// selectors are always in range, so indices never step outside the arrays
	always_comb begin
		int ai;
		int ii;
		int fi;
		ai = int'(axis_q) - 1;
		ii = int'(inst_q) - 1;
		fi = 0;
		value_d = '0;
		if (source_q >= safety_monitor_pkg::SRC_TORQUE_OFF
			&& source_q <= safety_monitor_pkg::SRC_BRAKE_CTRL) begin
			fi = int'(source_q) - 1;
			value_d = VW'(fn_state[ai][ii][fi]);
		end else if (source_q == safety_monitor_pkg::SRC_BRAKE) begin
			// axis ignored; instances past the last brake read zero
			if (ii < NUM_BRAKES) begin
				value_d = VW'(brake_state[ii]);
			end
		end else if (source_q == safety_monitor_pkg::SRC_POSITION) begin
			value_d = position[ai];
		end else if (source_q == safety_monitor_pkg::SRC_ABS_POSITION) begin
			value_d = abs_position[ai];
		end else if (source_q == safety_monitor_pkg::SRC_ACCEL) begin
			value_d = accel[ai];
		end else if (source_q == safety_monitor_pkg::SRC_SPEED) begin
			value_d = speed[ai];
		end else if (source_q >= safety_monitor_pkg::SRC_FN_FIRST) begin
			fi = int'(source_q - safety_monitor_pkg::SRC_FN_FIRST)
				+ safety_monitor_pkg::FN_LOW_SLOTS;
			value_d = VW'(fn_state[ai][ii][fi]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value_q <= '0;
		end else begin
			value_q <= value_d;
		end
	end
endmodule : monitor_channel

/* src/safety_monitor_pkg.sv */
package safety_monitor_pkg;
	// selector ranges and reset values
	localparam logic [7:0] SRC_MIN = 8'h00;
	localparam logic [7:0] SRC_MAX = 8'h14;
	localparam logic [7:0] SRC_RESET = 8'h01;
	localparam logic [7:0] AXIS_MIN = 8'h01;
	localparam logic [7:0] AXIS_RESET = 8'h01;
	localparam logic [7:0] INST_MIN = 8'h01;
	localparam logic [7:0] INST_MAX = 8'h04;
	localparam logic [7:0] INST_RESET = 8'h01;
	// source codes
	localparam logic [7:0] SRC_TORQUE_OFF = 8'h01;
	localparam logic [7:0] SRC_STOP1 = 8'h02;
	localparam logic [7:0] SRC_BRAKE_CTRL = 8'h03;
	localparam logic [7:0] SRC_BRAKE = 8'h04;
	localparam logic [7:0] SRC_POSITION = 8'h05;
	localparam logic [7:0] SRC_ABS_POSITION = 8'h06;
	localparam logic [7:0] SRC_ACCEL = 8'h07;
	localparam logic [7:0] SRC_SPEED = 8'h08;
	localparam logic [7:0] SRC_FN_FIRST = 8'h09;
	// function slots: 0..2 for codes 1..3, 3..14 for codes 9..20
	localparam int NUM_FN = 15;
	localparam int FN_LOW_SLOTS = 3;
	// unit state codes
	localparam logic [15:0] ST_STARTUP = 16'h0001;
	localparam logic [15:0] ST_NODE_ID = 16'h0002;
	localparam logic [15:0] ST_CFG_REQUIRED = 16'h0003;
	localparam logic [15:0] ST_CFG_INVALID = 16'h0004;
	localparam logic [15:0] ST_PARAM_VALIDATE = 16'h0005;
	localparam logic [15:0] ST_NORMAL = 16'h0006;
	localparam logic [15:0] ST_BRAKE_TEST = 16'h0007;
	localparam logic [15:0] ST_IO_FAILURE = 16'h0008;
	localparam logic [15:0] ST_INT_FAILURE = 16'h0009;
	// object dictionary location of the state code
	localparam logic [15:0] OD_STATE_INDEX = 16'h37C1;
	localparam logic [7:0] OD_STATE_SUBINDEX = 8'h00;

	typedef enum logic [8:0] {
		U_STARTUP = 9'h001,
		U_NODE_ID = 9'h002,
		U_CFG_REQ = 9'h004,
		U_CFG_INV = 9'h008,
		U_PARAM = 9'h010,
		U_NORMAL = 9'h020,
		U_BRAKE_TEST = 9'h040,
		U_IO_FAIL = 9'h080,
		U_INT_FAIL = 9'h100
	} unit_state_t;
endpackage : safety_monitor_pkg

/* src/safety_monitor_select_and_state.sv */
// Function
// - instance selector per channel, range 1 to 4, resets to 1.
// - source selector per channel, codes 0 to 20, resets to 1.
// - codes 1-3 report torque-off, stop1 and brake-control machine states.
// - code 4 reports brake machine state, axis ignored, instance picks brake.
// - codes 5-8 report position, absolute position, acceleration, speed of axis.
// - codes 9-20 report the twelve further function machine states in order.
// - state code readable on console output and dictionary entry 0x37C1/0.
// - state reads 1 during start-up while fieldbus link comes up.
// - state reads 2 when node identifier is missing or not validated.
// - state 3 when configuration required, 4 when last configuration invalid.
// - state 5 while parameters unvalidated, 6 in normal operation.
// - state 7 during drive-triggered brake test, for the whole unit.
// - state 8 after acknowledgeable I/O fault; torque-off and brakes held.
// - state 9 after internal failure, latched until power cycle.
// - each channel value is read-only and follows its three selectors.
// - axis selector resets to 1, accepts 1 to axis count.
`timescale 1ns/100ps
module safety_monitor_select_and_state #(
	parameter int NUM_CH = 2,
	parameter int NUM_AXES = 2,
	parameter int NUM_INST = 4,
	parameter int NUM_BRAKES = 2,
	parameter int VW = 32
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic src_wr [NUM_CH], // source selector write strobe
	input wire logic axis_wr [NUM_CH], // axis selector write strobe
	input wire logic inst_wr [NUM_CH], // instance selector write strobe
	input wire logic [7:0] wr_data [NUM_CH], // selector write value
	input wire logic [7:0] fn_state [NUM_AXES][NUM_INST][safety_monitor_pkg::NUM_FN], // fn states
	input wire logic [7:0] brake_state [NUM_BRAKES], // brake machine states
	input wire logic [VW-1:0] position [NUM_AXES], // safe position per axis
	input wire logic [VW-1:0] abs_position [NUM_AXES], // safe absolute position
	input wire logic [VW-1:0] accel [NUM_AXES], // acceleration per axis
	input wire logic [VW-1:0] speed [NUM_AXES], // speed per axis
	input wire logic link_up, // safe fieldbus connection established
	input wire logic node_id_valid, // node identifier present and validated
	input wire logic cfg_broken, // stored configuration may be broken
	input wire logic cfg_invalid, // last configuration found invalid
	input wire logic params_valid, // safety parameters validated
	input wire logic brake_test, // brake test requested by drive processor
	input wire logic io_fault, // acknowledgeable I/O fault detected
	input wire logic io_ack, // acknowledge of I/O fault
	input wire logic int_fault, // catastrophic internal failure
	input wire logic od_rd, // dictionary read strobe
	input wire logic [15:0] od_index, // dictionary index
	input wire logic [7:0] od_subindex, // dictionary subindex
	output logic [7:0] mon_source [NUM_CH], // held source codes
	output logic [7:0] mon_axis [NUM_CH], // held axis selectors
	output logic [7:0] mon_inst [NUM_CH], // held instance selectors
	output logic [VW-1:0] mon_value [NUM_CH], // monitored values
	output logic sel_reject [NUM_CH], // pulse: selector write rejected
	output logic [15:0] state_code_q, // unit state code for console
	output logic torque_off_hold_q, // force torque-off
	output logic brake_hold_q, // force all brakes on
	output logic od_valid_q, // pulse: dictionary answer
	output logic od_abort_q, // pulse with valid: unknown entry
	output logic [15:0] od_data_q // dictionary read data
);
	safety_monitor_pkg::unit_state_t state_q, state_d;

	// both channels see the same quantities; each keeps its own selectors
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			monitor_channel #(
				.NUM_AXES(NUM_AXES),
				.NUM_INST(NUM_INST),
				.NUM_BRAKES(NUM_BRAKES),
				.VW(VW)
			) monitor_channel_i (
				.clk(clk),
				.rst(rst),
				.src_wr(src_wr[c]),
				.axis_wr(axis_wr[c]),
				.inst_wr(inst_wr[c]),
				.wr_data(wr_data[c]),
				.fn_state(fn_state),
				.brake_state(brake_state),
				.position(position),
				.abs_position(abs_position),
				.accel(accel),
				.speed(speed),
				.source_q(mon_source[c]),
				.axis_q(mon_axis[c]),
				.inst_q(mon_inst[c]),
				.value_q(mon_value[c]),
				.reject_q(sel_reject[c])
			);
		end
	endgenerate

	// 255 has no defined meaning here, so it is never produced
	function automatic logic [15:0] state_code(input safety_monitor_pkg::unit_state_t s);
		case (s)
			safety_monitor_pkg::U_STARTUP: state_code = safety_monitor_pkg::ST_STARTUP;
			safety_monitor_pkg::U_NODE_ID: state_code = safety_monitor_pkg::ST_NODE_ID;
			safety_monitor_pkg::U_CFG_REQ: state_code = safety_monitor_pkg::ST_CFG_REQUIRED;
			safety_monitor_pkg::U_CFG_INV: state_code = safety_monitor_pkg::ST_CFG_INVALID;
			safety_monitor_pkg::U_PARAM: state_code = safety_monitor_pkg::ST_PARAM_VALIDATE;
			safety_monitor_pkg::U_NORMAL: state_code = safety_monitor_pkg::ST_NORMAL;
			safety_monitor_pkg::U_BRAKE_TEST: state_code = safety_monitor_pkg::ST_BRAKE_TEST;
			safety_monitor_pkg::U_IO_FAIL: state_code = safety_monitor_pkg::ST_IO_FAILURE;
			default: state_code = safety_monitor_pkg::ST_INT_FAILURE;
		endcase
	endfunction : state_code

	// failures first; an unacknowledged I/O fault keeps its state even if the cause clears
	always_comb begin
		state_d = state_q;
		case (state_q)
			safety_monitor_pkg::U_INT_FAIL: begin
				state_d = safety_monitor_pkg::U_INT_FAIL;
			end
			safety_monitor_pkg::U_IO_FAIL: begin
				if (int_fault) begin
					state_d = safety_monitor_pkg::U_INT_FAIL;
				end else if (io_ack && !io_fault) begin
					state_d = safety_monitor_pkg::U_STARTUP;
				end
			end
			default: begin
				if (int_fault) begin
					state_d = safety_monitor_pkg::U_INT_FAIL;
				end else if (io_fault) begin
					state_d = safety_monitor_pkg::U_IO_FAIL;
				end else if (!link_up) begin
					state_d = safety_monitor_pkg::U_STARTUP;
				end else if (!node_id_valid) begin
					state_d = safety_monitor_pkg::U_NODE_ID;
				end else if (cfg_broken) begin
					state_d = safety_monitor_pkg::U_CFG_REQ;
				end else if (cfg_invalid) begin
					state_d = safety_monitor_pkg::U_CFG_INV;
				end else if (!params_valid) begin
					state_d = safety_monitor_pkg::U_PARAM;
				end else if (brake_test) begin
					state_d = safety_monitor_pkg::U_BRAKE_TEST;
				end else begin
					state_d = safety_monitor_pkg::U_NORMAL;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= safety_monitor_pkg::U_STARTUP;
		end else begin
			state_q <= state_d;
		end
	end

	// registered from the next state so the code lines up with state_q
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_code_q <= safety_monitor_pkg::ST_STARTUP;
		end else begin
			state_code_q <= state_code(state_d);
		end
	end

	// start-up counts as unsafe too, so nothing is released before the link is up
	function automatic logic hold_required(input safety_monitor_pkg::unit_state_t s);
		hold_required = s == safety_monitor_pkg::U_IO_FAIL
			|| s == safety_monitor_pkg::U_INT_FAIL
			|| s == safety_monitor_pkg::U_STARTUP;
	endfunction : hold_required

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			torque_off_hold_q <= 1'b1;
		end else begin
			torque_off_hold_q <= hold_required(state_d);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			brake_hold_q <= 1'b1;
		end else begin
			brake_hold_q <= hold_required(state_d);
		end
	end

	// only one dictionary entry lives in this block
	function automatic logic od_hit(input logic [15:0] idx, input logic [7:0] sub);
		od_hit = idx == safety_monitor_pkg::OD_STATE_INDEX
			&& sub == safety_monitor_pkg::OD_STATE_SUBINDEX;
	endfunction : od_hit

	// every read is answered one cycle later, known entry or not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_valid_q <= 1'b0;
		end else begin
			od_valid_q <= od_rd;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_abort_q <= 1'b0;
		end else begin
			od_abort_q <= od_rd && !od_hit(od_index, od_subindex);
		end
	end

	// data carries the code held at the request edge, not the one being computed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			od_data_q <= 16'h0000;
		end else if (od_rd && od_hit(od_index, od_subindex)) begin
			od_data_q <= state_code_q;
		end else begin
			od_data_q <= 16'h0000;
		end
	end
endmodule : safety_monitor_select_and_state

/* testbench/safety_monitor_monitor.sv */
`timescale 1ns/100ps
module safety_monitor_monitor #(
	parameter int NUM_CH = 2,
	parameter int NUM_AXES = 2,
	parameter int VW = 32
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic src_wr [NUM_CH], // source write
	input wire logic [7:0] wr_data [NUM_CH], // write value
	input wire logic [VW-1:0] speed [NUM_AXES], // speeds
	input wire logic link_up, // link up
	input wire logic io_fault, // io fault
	input wire logic int_fault, // internal fault
	input wire logic od_rd, // dictionary read
	input wire logic [15:0] od_index, // index
	input wire logic [7:0] od_subindex, // subindex
	input wire logic [7:0] mon_source [NUM_CH], // sources
	input wire logic [7:0] mon_axis [NUM_CH], // axes
	input wire logic [VW-1:0] mon_value [NUM_CH], // values
	input wire logic sel_reject [NUM_CH], // rejects
	input wire logic [15:0] state_code_q, // state
	input wire logic torque_off_hold_q, // hold
	input wire logic brake_hold_q, // hold
	input wire logic od_valid_q, // answer
	input wire logic od_abort_q, // abort
	input wire logic [15:0] od_data_q // data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	state_range_a: assert property (state_code_q inside {[16'h0001:16'h0009]})
		else $error("state code out of range");
	int_latch_a: assert property (int_fault |=> state_code_q == 16'h0009)
		else $error("internal fault not reported");
	int_stay_a: assert property (state_code_q == 16'h0009 |=> state_code_q == 16'h0009)
		else $error("internal failure left");
	io_fault_a: assert property (io_fault && !int_fault && state_code_q != 16'h0009
		|=> state_code_q == 16'h0008)
		else $error("io fault not reported");
	io_hold_a: assert property (state_code_q == 16'h0008 |-> torque_off_hold_q && brake_hold_q)
		else $error("holds released in io failure");
	startup_state_a: assert property (!link_up && !io_fault && !int_fault
		&& state_code_q < 16'h0008 |=> state_code_q == 16'h0001)
		else $error("start-up state missing");
	od_answer_a: assert property (od_rd && od_index == 16'h37C1 && od_subindex == 8'h00
		|=> od_valid_q && !od_abort_q && od_data_q == $past(state_code_q))
		else $error("dictionary state read wrong");
	od_abort_a: assert property (od_rd && od_index != 16'h37C1 |=> od_valid_q && od_abort_q)
		else $error("unknown entry not aborted");
	src_reject_a: assert property (src_wr[0] && wr_data[0] > 8'h14
		|=> sel_reject[0] && mon_source[0] == $past(mon_source[0]))
		else $error("bad source accepted");
	src_take_a: assert property (src_wr[0] && wr_data[0] <= 8'h14
		|=> mon_source[0] == $past(wr_data[0]) && !sel_reject[0])
		else $error("source write lost");
	speed_route_a: assert property (mon_source[0] == 8'h08 && mon_axis[0] == 8'h02
		|=> mon_value[0] == $past(speed[1]))
		else $error("speed not routed");
	cover property (state_code_q == 16'h0009);
	cover property (sel_reject[0]);
	cover property (od_valid_q && !od_abort_q);
endmodule : safety_monitor_monitor

bind safety_monitor_select_and_state safety_monitor_monitor #(.NUM_CH(NUM_CH),
	.NUM_AXES(NUM_AXES), .VW(VW)) safety_monitor_monitor_i (.clk(clk), .rst(rst),
	.src_wr(src_wr), .wr_data(wr_data), .speed(speed), .link_up(link_up),
	.io_fault(io_fault), .int_fault(int_fault), .od_rd(od_rd), .od_index(od_index),
	.od_subindex(od_subindex), .mon_source(mon_source), .mon_axis(mon_axis),
	.mon_value(mon_value), .sel_reject(sel_reject), .state_code_q(state_code_q),
	.torque_off_hold_q(torque_off_hold_q), .brake_hold_q(brake_hold_q),
	.od_valid_q(od_valid_q), .od_abort_q(od_abort_q), .od_data_q(od_data_q));

/* testbench/safety_monitor_select_and_state_tb.sv */
`timescale 1ns/100ps
module safety_monitor_select_and_state_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic src_wr [2], axis_wr [2], inst_wr [2], sel_reject [2];
	logic [7:0] wr_data [2], mon_source [2], mon_axis [2], mon_inst [2];
	logic [7:0] fn_state [2][4][safety_monitor_pkg::NUM_FN];
	logic [7:0] brake_state [2];
	logic [31:0] position [2], abs_position [2], accel [2], speed [2], mon_value [2];
	logic link_up, node_id_valid, cfg_broken, cfg_invalid, params_valid;
	logic brake_test, io_fault, io_ack, int_fault, od_rd;
	logic torque_off_hold_q, brake_hold_q, od_valid_q, od_abort_q;
	logic [15:0] od_index, state_code_q, od_data_q;
	logic [7:0] od_subindex;
	int miscompares = 0;
	int total_checks = 0;
	always #12.5 clk = ~clk;
	safety_monitor_select_and_state safety_monitor_select_and_state_i (.clk(clk), .rst(rst),
		.src_wr(src_wr), .axis_wr(axis_wr), .inst_wr(inst_wr), .wr_data(wr_data),
		.fn_state(fn_state), .brake_state(brake_state), .position(position),
		.abs_position(abs_position), .accel(accel), .speed(speed), .link_up(link_up),
		.node_id_valid(node_id_valid), .cfg_broken(cfg_broken), .cfg_invalid(cfg_invalid),
		.params_valid(params_valid), .brake_test(brake_test), .io_fault(io_fault),
		.io_ack(io_ack), .int_fault(int_fault), .od_rd(od_rd), .od_index(od_index),
		.od_subindex(od_subindex), .mon_source(mon_source), .mon_axis(mon_axis),
		.mon_inst(mon_inst), .mon_value(mon_value), .sel_reject(sel_reject),
		.state_code_q(state_code_q), .torque_off_hold_q(torque_off_hold_q),
		.brake_hold_q(brake_hold_q), .od_valid_q(od_valid_q), .od_abort_q(od_abort_q),
		.od_data_q(od_data_q));
	task automatic complete_run();
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// kind 0 source, 1 axis, 2 instance; strobe dropped at the taking edge
	task automatic wr(input int c, input int kind, input logic [7:0] v);
		@(posedge clk);
		wr_data[c] <= v;
		case (kind)
			0: src_wr[c] <= 1'b1;
			1: axis_wr[c] <= 1'b1;
			default: inst_wr[c] <= 1'b1;
		endcase
		@(posedge clk);
		src_wr[c] <= 1'b0;
		axis_wr[c] <= 1'b0;
		inst_wr[c] <= 1'b0;
		#1;
	endtask : wr
	function automatic logic [31:0] exp_val(input int s, input int a, input int i);
		if (s == 0) return 32'h0000_0000;
		if (s <= 3) return 32'(fn_state[a-1][i-1][s-1]);
		if (s == 4) return (i <= 2) ? 32'(brake_state[i-1]) : 32'h0000_0000;
		if (s == 5) return position[a-1];
		if (s == 6) return abs_position[a-1];
		if (s == 7) return accel[a-1];
		if (s == 8) return speed[a-1];
		return 32'(fn_state[a-1][i-1][s-6]);
	endfunction : exp_val
	// input order: link node cfg_broken cfg_invalid params brake_test io_fault ack int
	task automatic st(input logic [8:0] v, input logic [15:0] exp, input int n);
		@(posedge clk);
		{link_up, node_id_valid, cfg_broken, cfg_invalid, params_valid, brake_test,
			io_fault, io_ack, int_fault} <= v;
		repeat (n) @(posedge clk);
		#1;
		chk("state_code_q", 32'(exp), 32'(state_code_q));
	endtask : st
	task automatic od(input logic [15:0] idx, input logic [7:0] sub, input logic ab);
		@(posedge clk);
		od_rd <= 1'b1;
		od_index <= idx;
		od_subindex <= sub;
		@(posedge clk);
		od_rd <= 1'b0;
		#1;
		chk("od_valid_q", 32'h1, 32'(od_valid_q));
		chk("od_abort_q", 32'(ab), 32'(od_abort_q));
		chk("od_data_q", ab ? 32'h0 : 32'h6, 32'(od_data_q));
	endtask : od
	task automatic test_defaults();
		chk("mon_source", 32'h1, 32'(mon_source[0]));
		chk("mon_axis", 32'h1, 32'(mon_axis[1]));
		chk("mon_inst", 32'h1, 32'(mon_inst[0]));
		chk("state_code_q", 32'h1, 32'(state_code_q));
		chk("torque_off_hold_q", 32'h1, 32'(torque_off_hold_q));
	endtask : test_defaults
	task automatic test_sources();
		wr(0, 1, 8'h02);
		wr(0, 2, 8'h02);
		for (int k = 0; k <= 20; k++) begin
			wr(0, 0, 8'(k));
			@(posedge clk);
			#1;
			chk("mon_value", exp_val(k, 2, 2), mon_value[0]);
			chk("other mon_value", exp_val(1, 1, 1), mon_value[1]);
		end
		chk("mon_source", 32'h14, 32'(mon_source[0]));
	endtask : test_sources
	task automatic test_reject();
		wr(0, 0, 8'h15);
		chk("sel_reject", 32'h1, 32'(sel_reject[0]));
		chk("mon_source", 32'h14, 32'(mon_source[0]));
		wr(1, 1, 8'h03);
		chk("mon_axis", 32'h1, 32'(mon_axis[1]));
		wr(1, 2, 8'h00);
		chk("sel_reject", 32'h1, 32'(sel_reject[1]));
		wr(1, 2, 8'h05);
		chk("mon_inst", 32'h1, 32'(mon_inst[1]));
		wr(1, 2, 8'h04);
		chk("sel_reject", 32'h0, 32'(sel_reject[1]));
		chk("mon_inst", 32'h4, 32'(mon_inst[1]));
		wr(1, 0, 8'h04);
		@(posedge clk);
		#1;
		chk("mon_value", exp_val(4, 1, 4), mon_value[1]);
	endtask : test_reject
	task automatic test_state();
		st(9'h090, 16'h0001, 2);
		st(9'h110, 16'h0002, 2);
		st(9'h1D0, 16'h0003, 2);
		st(9'h1B0, 16'h0004, 2);
		st(9'h180, 16'h0005, 2);
		st(9'h198, 16'h0007, 2);
		st(9'h190, 16'h0006, 2);
		chk("brake_hold_q", 32'h0, 32'(brake_hold_q));
		od(16'h37C1, 8'h00, 1'b0);
		od(16'h37C2, 8'h00, 1'b1);
		od(16'h37C1, 8'h01, 1'b1);
		st(9'h194, 16'h0008, 2);
		chk("brake_hold_q", 32'h1, 32'(brake_hold_q));
		st(9'h190, 16'h0008, 3);
		st(9'h192, 16'h0006, 3);
		st(9'h191, 16'h0009, 2);
		st(9'h190, 16'h0009, 4);
	endtask : test_state
	// a second reset is the only way out of the latched failure
	task automatic test_rereset();
		@(posedge clk);
		rst <= 1'b1;
		link_up <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		test_defaults();
	endtask : test_rereset
	initial begin
		{link_up, node_id_valid, cfg_broken, cfg_invalid, params_valid, brake_test,
			io_fault, io_ack, int_fault, od_rd} = 10'h000;
		od_index = 16'h0000;
		od_subindex = 8'h00;
		for (int a = 0; a < 2; a++) begin
			src_wr[a] = 1'b0;
			axis_wr[a] = 1'b0;
			inst_wr[a] = 1'b0;
			wr_data[a] = 8'h00;
			brake_state[a] = 8'hB0 + 8'(a);
			position[a] = 32'h1000_0000 + 32'(a);
			abs_position[a] = 32'h2000_0000 + 32'(a);
			accel[a] = 32'h3000_0000 + 32'(a);
			speed[a] = 32'h4000_0000 + 32'(a);
			for (int i = 0; i < 4; i++) begin
				for (int s = 0; s < safety_monitor_pkg::NUM_FN; s++) begin
					fn_state[a][i][s] = 8'(a * 64 + i * 16 + s);
				end
			end
		end
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		test_defaults();
		test_sources();
		test_reject();
		test_state();
		test_rereset();
		complete_run();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#125000;
		miscompares++;
		complete_run();
	end
endmodule : safety_monitor_select_and_state_tb
